// ### das_port_pkg.sv
// Package with shared constants for the acquisition parallel port
package das_port_pkg;
  // ****************************************************************
  // Widths and codes
  // ****************************************************************
  localparam int DATA_W       = 8;
  localparam int ADDR_W       = 16;
  localparam int LOW_ADDR_W   = 8;
  localparam logic [7:0] PIE_CTRL_WORD = 8'h99;   // Octal 231, port B outputs
  localparam logic [7:0] RESET_MATCH   = 8'h00;
  localparam logic [7:0] RESET_POLAR   = 8'h00;
  localparam logic [7:0] RESET_HIGH    = 8'hF0;
  localparam logic [7:0] IO_PORT_ADDR  = 8'h40;
  localparam logic [7:0] MEM_PORT_PAGE = 8'hF0;
endpackage

// ### das_port_if.sv
// Interface joining the processor bus end and the acquisition end
`timescale 1ns/1ns
interface das_port_if;
  logic [15:0] lowAddressLines;
  logic        ioReadStrobeN;
  logic        ioWriteStrobeN;
  logic        memoryReadStrobeN;
  logic        memoryWriteStrobeN;
  logic [7:0]  cpuDataOut;
  logic        cpuDataOe;
  logic [7:0]  devDataOut;
  logic        devDataOe;
  logic        interruptRequest;
  wire  [7:0]  bidirDataLines;

  assign bidirDataLines = cpuDataOe ? cpuDataOut : (devDataOe ? devDataOut : 8'hFF);

  modport device (
    input  lowAddressLines, ioReadStrobeN, ioWriteStrobeN,
    input  memoryReadStrobeN, memoryWriteStrobeN, cpuDataOut, cpuDataOe,
    output devDataOut, devDataOe, interruptRequest
  );
  modport host (
    output lowAddressLines, ioReadStrobeN, ioWriteStrobeN,
    output memoryReadStrobeN, memoryWriteStrobeN, cpuDataOut, cpuDataOe,
    input  devDataOut, devDataOe, interruptRequest, bidirDataLines
  );
endinterface

// ### das_port_device.sv
// Acquisition end: write latch, two read buffer groups, decode, interrupt latch
`timescale 1ns/1ns
module das_port_device #(
  parameter logic [7:0] PORT_MATCH = das_port_pkg::IO_PORT_ADDR,
  parameter logic [7:0] HIGH_MATCH = das_port_pkg::MEM_PORT_PAGE
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  das_port_if.device      bus,
  input  wire logic       memoryMapped,
  input  wire logic [7:0] polarityJumpers,
  input  wire logic [7:0] statusMsbWord,
  input  wire logic [7:0] lowDataWord,
  input  wire logic       conversionStatus,
  output logic      [7:0] controlWord,
  output logic            controlStrobe
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [15:0] addrS1;
  logic [15:0] addrS2;
  logic [3:0]  strbS1;
  logic [3:0]  strbS2;
  logic [7:0]  dataS1;
  logic [7:0]  dataS2;
  logic        statS1;
  logic        statS2;
  logic        statPrev;
  logic        mmS1;
  logic        mmS2;
  logic [7:0]  polS1;
  logic [7:0]  polS2;
  logic [7:0]  msbS1;
  logic [7:0]  msbS2;
  logic [7:0]  lowS1;
  logic [7:0]  lowS2;

  // Address lines
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addrS1 <= 16'h0000;
      addrS2 <= 16'h0000;
    end else begin
      addrS1 <= bus.lowAddressLines;
      addrS2 <= addrS1;
    end
  end

  // Strobes, idle high
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strbS1 <= 4'hF;
      strbS2 <= 4'hF;
    end else begin
      strbS1 <= {bus.ioReadStrobeN, bus.ioWriteStrobeN,
                 bus.memoryReadStrobeN, bus.memoryWriteStrobeN};
      strbS2 <= strbS1;
    end
  end

  // Write data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dataS1 <= 8'h00;
      dataS2 <= 8'h00;
    end else begin
      dataS1 <= bus.cpuDataOut;
      dataS2 <= dataS1;
    end
  end

  // Converter status and its previous value for edge detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      statS1   <= 1'b0;
      statS2   <= 1'b0;
      statPrev <= 1'b0;
    end else begin
      statS1   <= conversionStatus;
      statS2   <= statS1;
      statPrev <= statS2;
    end
  end

  // Mode and polarity jumpers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mmS1  <= 1'b0;
      mmS2  <= 1'b0;
      polS1 <= 8'h00;
      polS2 <= 8'h00;
    end else begin
      mmS1  <= memoryMapped;
      mmS2  <= mmS1;
      polS1 <= polarityJumpers;
      polS2 <= polS1;
    end
  end

  // Words offered to the read groups
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      msbS1 <= 8'h00;
      msbS2 <= 8'h00;
      lowS1 <= 8'h00;
      lowS2 <= 8'h00;
    end else begin
      msbS1 <= statusMsbWord;
      msbS2 <= msbS1;
      lowS1 <= lowDataWord;
      lowS2 <= lowS1;
    end
  end

  // ****************************************************************
  // Address decode and strobe selection
  // ****************************************************************
  logic [7:0] bitMatch;
  logic       decodeN, readActive, writeActive;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_match
      assign bitMatch[i] = ~(addrS2[i] ^ PORT_MATCH[i] ^ polS2[i]);
    end
  endgenerate

  assign decodeN = ~(&bitMatch && (!mmS2 || addrS2[15:8] == HIGH_MATCH));

  // ****************************************************************
  // Strobe selection
  // ****************************************************************
  // Mode picks the strobe pair here and adds the high byte check in decodeN; gating below is shared
  assign readActive  = mmS2 ? !strbS2[1] : !strbS2[3];
  assign writeActive = mmS2 ? !strbS2[0] : !strbS2[2];

  logic readGate, writeGate, writePrev;
  assign readGate  = readActive && !decodeN;
  assign writeGate = writeActive && !decodeN;

  // ****************************************************************
  // Write latch
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      controlWord   <= 8'h00;
      controlStrobe <= 1'b0;
      writePrev     <= 1'b0;
    end else begin
      writePrev     <= writeGate;
      controlStrobe <= 1'b0;
      if (writeGate && !writePrev) begin
        controlWord   <= dataS2;
        controlStrobe <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read buffer groups
  // ****************************************************************
  // Output enable follows the decoded read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.devDataOe <= 1'b0;
    end else begin
      bus.devDataOe <= readGate;
    end
  end

  // Group select by the lowest address line
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.devDataOut <= 8'h00;
    end else begin
      bus.devDataOut <= addrS2[0] ? msbS2 : lowS2;
    end
  end

  // ****************************************************************
  // Interrupt latch
  // ****************************************************************
  logic readPrev;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readPrev <= 1'b0;
    end else begin
      readPrev <= readGate && addrS2[0];
    end
  end

  // Set wins over clear when both fall in one cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.interruptRequest <= 1'b0;
    end else if (statS2 && !statPrev) begin
      bus.interruptRequest <= 1'b1;
    end else if (readPrev && !(readGate && addrS2[0])) begin
      bus.interruptRequest <= 1'b0;
    end
  end
endmodule

// ### das_port_host.sv
// Processor end: drives strobes, address and data for one transfer at a time
`timescale 1ns/1ns
module das_port_host (
  input  wire logic        mclk,
  input  wire logic        reset,
  das_port_if.host         bus,
  input  wire logic        memoryMapped,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [15:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             reqBusy,
  output logic      [7:0]  rspData,
  output logic             rspValid,
  output logic             irqSeen
);
  localparam logic [2:0] HOLD = 3'h6;
  logic [2:0] count;
  logic       isWrite;
  logic       irqS1;

  // ****************************************************************
  // Strobe sequencer
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus.lowAddressLines    <= 16'h0000;
      bus.ioReadStrobeN      <= 1'b1;
      bus.ioWriteStrobeN     <= 1'b1;
      bus.memoryReadStrobeN  <= 1'b1;
      bus.memoryWriteStrobeN <= 1'b1;
      bus.cpuDataOut         <= 8'h00;
      bus.cpuDataOe          <= 1'b0;
      reqBusy  <= 1'b0;
      rspData  <= 8'h00;
      rspValid <= 1'b0;
      count    <= 3'h0;
      isWrite  <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      if (!reqBusy && reqValid) begin
        reqBusy <= 1'b1;
        isWrite <= reqWrite;
        count   <= 3'h0;
        bus.lowAddressLines <= reqAddr;
        bus.cpuDataOut      <= reqData;
        bus.cpuDataOe       <= reqWrite;
        // Only the strobe pair of the chosen mode moves
        bus.ioReadStrobeN      <= !(!memoryMapped && !reqWrite);
        bus.ioWriteStrobeN     <= !(!memoryMapped && reqWrite);
        bus.memoryReadStrobeN  <= !(memoryMapped && !reqWrite);
        bus.memoryWriteStrobeN <= !(memoryMapped && reqWrite);
      end else if (reqBusy) begin
        count <= count + 3'h1;
        if (count == HOLD) begin
          if (!isWrite) begin
            rspData  <= bus.bidirDataLines;
            rspValid <= 1'b1;
          end
          bus.ioReadStrobeN      <= 1'b1;
          bus.ioWriteStrobeN     <= 1'b1;
          bus.memoryReadStrobeN  <= 1'b1;
          bus.memoryWriteStrobeN <= 1'b1;
        end else if (count == HOLD + 3'h1) begin
          bus.cpuDataOe <= 1'b0;
          reqBusy       <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Interrupt input synchroniser
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqS1   <= 1'b0;
      irqSeen <= 1'b0;
    end else begin
      irqS1   <= bus.interruptRequest;
      irqSeen <= irqS1;
    end
  end
endmodule

// ### das_port_assertions.sv
// Assertions on the link between the processor end and the acquisition end
`timescale 1ns/1ns
module das_port_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ioReadStrobeN,
  input wire logic ioWriteStrobeN,
  input wire logic memoryReadStrobeN,
  input wire logic memoryWriteStrobeN,
  input wire logic cpuDataOe,
  input wire logic devDataOe,
  input wire logic interruptRequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire readIdle  = ioReadStrobeN & memoryReadStrobeN;
  wire writeIdle = ioWriteStrobeN & memoryWriteStrobeN;
  a_one_bus_driver: assert property (!(cpuDataOe && devDataOe))
    else $error("both ends drive the data lines");
  a_oe_after_read: assert property (devDataOe |-> !$past(readIdle, 3))
    else $error("read buffers on without a read strobe");
  a_oe_released: assert property (readIdle [*4] |-> !devDataOe)
    else $error("read buffers left on after the strobe");
  a_write_strobe_width: assert property ($fell(ioWriteStrobeN) |->
    (!ioWriteStrobeN) [*7] ##1 ioWriteStrobeN) else $error("write strobe width wrong");
  a_one_mode_strobes: assert property (!(!(readIdle & writeIdle) &&
    (!memoryReadStrobeN || !memoryWriteStrobeN) && (!ioReadStrobeN || !ioWriteStrobeN)))
    else $error("strobes of both modes active");
  a_read_write_apart: assert property (!(!readIdle && !writeIdle))
    else $error("read and write strobes together");
  a_irq_holds: assert property (interruptRequest && !devDataOe && !$past(devDataOe)
    && !$past(devDataOe, 2) |=> interruptRequest) else $error("request dropped unread");
  a_irq_clear_cause: assert property ($fell(interruptRequest) |->
    ($past(devDataOe) || $past(devDataOe, 2) || $past(devDataOe, 3)))
    else $error("request cleared without a read");
  cover property ($rose(devDataOe));
  cover property ($fell(interruptRequest));
  cover property ($fell(memoryWriteStrobeN));
endmodule

// ### das_cpu_parallel_interface_bench.sv
// Self-checking bench for the acquisition parallel port with both ends joined
`timescale 1ns/1ns
module das_cpu_parallel_interface_bench;
  logic        mclk = 0, reset = 1, devMm = 0, hostMm = 0, reqValid = 0, reqWrite = 0;
  logic        convStatus = 0;
  logic [15:0] reqAddr = 16'h0000, good, bad;
  logic [7:0]  reqData = 8'h00, jumpers = 8'h00, msbWord = 8'h00, lowWord = 8'h00;
  logic [7:0]  j, m, l, d, r;
  wire  [7:0]  controlWord, rspData;
  wire         rspValid, reqBusy, irqSeen, controlStrobe;
  int          failures = 0, check_count = 0, i, k, v, strobes = 0;
  integer      seed = 32'hD7C8;
  das_port_if link ();
  always #25 mclk = ~mclk;
  das_port_device das_port_device_inst (.mclk(mclk), .reset(reset), .bus(link.device),
    .memoryMapped(devMm), .polarityJumpers(jumpers), .statusMsbWord(msbWord),
    .lowDataWord(lowWord), .conversionStatus(convStatus), .controlWord(controlWord),
    .controlStrobe(controlStrobe));
  das_port_host das_port_host_inst (.mclk(mclk), .reset(reset), .bus(link.host),
    .memoryMapped(hostMm), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqBusy(reqBusy), .rspData(rspData), .rspValid(rspValid),
    .irqSeen(irqSeen));
  always @(negedge mclk) begin
    if (controlStrobe === 1'b1) strobes++;
  end
  das_port_assertions das_port_assertions_inst (.mclk(mclk), .reset(reset),
    .ioReadStrobeN(link.ioReadStrobeN), .ioWriteStrobeN(link.ioWriteStrobeN),
    .memoryReadStrobeN(link.memoryReadStrobeN), .memoryWriteStrobeN(link.memoryWriteStrobeN),
    .cpuDataOe(link.cpuDataOe), .devDataOe(link.devDataOe),
    .interruptRequest(link.interruptRequest));
  task close_out;
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] dat);
    reqValid <= 1;
    reqWrite <= w;
    reqAddr  <= a;
    reqData  <= dat;
    @(posedge mclk);
    reqValid <= 0;
    k = 0;
    v = 0;
    do begin
      @(negedge mclk);
      k++;
      if (rspValid === 1'b1) begin
        r = rspData;
        v++;
      end
    end while (reqBusy !== 1'b0 && k < 40);
    if (k == 40) begin
      failures++;
      close_out();
    end
    chk(8'(v), {7'h00, ~w});
    @(posedge mclk);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    xfer(1, {8'h00, das_port_pkg::IO_PORT_ADDR}, das_port_pkg::PIE_CTRL_WORD);
    chk(controlWord, das_port_pkg::PIE_CTRL_WORD);
    for (i = 0; i < 12; i++) begin
      j = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      m = 8'($random(seed));
      l = 8'($random(seed));
      d = 8'($random(seed));
      good = {i[0] ? das_port_pkg::MEM_PORT_PAGE : 8'(i), das_port_pkg::IO_PORT_ADDR ^ j};
      bad = good ^ (i[0] ? 16'h0100 : 16'h0002);
      devMm <= i[0];
      hostMm <= i[0];
      jumpers <= j;
      msbWord <= m;
      lowWord <= l;
      convStatus <= 1;
      @(posedge mclk);
      xfer(1, good, d);
      chk(controlWord, d);
      xfer(1, bad, ~d);
      chk(controlWord, d);
      xfer(0, bad, 8'h00);
      chk(r, 8'hFF);
      hostMm <= ~i[0];
      xfer(1, good, ~d);
      chk(controlWord, d);
      xfer(0, good, 8'h00);
      chk(r, 8'hFF);
      hostMm <= i[0];
      chk({7'h00, link.interruptRequest}, 8'h01);
      xfer(0, good, 8'h00);
      chk(r, j[0] ? m : l);
      repeat (4) @(negedge mclk);
      chk({7'h00, link.interruptRequest}, {7'h00, ~j[0]});
      chk({7'h00, irqSeen}, {7'h00, ~j[0]});
      @(posedge mclk);
      convStatus <= 0;
      repeat (2) @(posedge mclk);
    end
    chk(8'(strobes), 8'h0D);
    close_out();
  end
endmodule
